// File: design/pio_pkg.sv
// Notes on behaviour
// RULE_01: Four byte ports plus one nibble port.
// RULE_02: Low port open-drain; ones release pin.
// RULE_03: Low port carries address/data in accesses.
// RULE_04: Zero-to-one write drives strong two clocks.
// RULE_05: Second port bit 0 timer event/clock out.
// RULE_06: Second port bit 1 timer capture input.
// RULE_07: High address port is pulled-up GPIO.
// RULE_08: High address port outputs high address byte.
// RULE_09: Address latch pulse during external accesses.
// RULE_10: Fourth port bits 0,1 serial rx/tx.
// RULE_11: Fourth port bits 2,3 external interrupts.
// RULE_12: Fourth port bits 4,5 timer event inputs.
// RULE_13: Output latches reset to all ones.
// RULE_14: Pin reads return synchronized pin levels.
package pio_pkg;
  localparam int PORT_W = 8;
  localparam int NIB_W = 4;
  localparam logic [7:0] LATCH_RST = 8'hFF;
  localparam logic [3:0] NIB_RST = 4'hF;
  localparam int CLK_PERIOD_NS = 50;
  localparam int STRONG_PERIODS = 2;
  localparam logic [1:0] STRONG_CYC = 2'(STRONG_PERIODS);
  // Bus cycle phases of an external access
  typedef enum logic [1:0] {
    PIO_IDLE = 2'b00,
    PIO_ADDR = 2'b01,
    PIO_DATA = 2'b11
  } pio_phase_t;
endpackage

// File: design/pio_ports.sv
`timescale 1ns/1ps
module pio_ports (
  input wire logic ref_clk,
  input wire logic rst_n,
  // Core write side
  input wire logic [3:0] wr_en,
  input wire logic wr_nib_en,
  input wire logic [7:0] wr_data,
  // Synchronized pin levels
  output logic [7:0] rd_low,
  output logic [7:0] rd_second,
  output logic [7:0] rd_high,
  output logic [7:0] rd_fourth,
  output logic [3:0] rd_nib,
  // External memory access
  input wire logic ext_start,
  input wire logic [15:0] ext_addr,
  input wire logic [7:0] ext_wdata,
  input wire logic ext_write,
  output logic addr_latch,
  // Alternate functions
  input wire logic timer_c_clk_out_en,
  input wire logic timer_c_clk_out,
  input wire logic serial_tx,
  output logic timer_c_event_or_clock_out,
  output logic timer_c_capture_control_in,
  output logic serial_rx,
  output logic external_irq_a,
  output logic external_irq_b,
  output logic timer_a_event_in,
  output logic timer_b_event_in,
  // Pins: input, output, enable per port
  input wire logic [7:0] low_in,
  output logic [7:0] low_out,
  output logic [7:0] low_oe,
  input wire logic [7:0] second_in,
  output logic [7:0] second_out,
  output logic [7:0] second_oe,
  input wire logic [7:0] high_in,
  output logic [7:0] high_out,
  output logic [7:0] high_oe,
  input wire logic [7:0] fourth_in,
  output logic [7:0] fourth_out,
  output logic [7:0] fourth_oe,
  input wire logic [3:0] nib_in,
  output logic [3:0] nib_out,
  output logic [3:0] nib_oe
);
  // Output latches of the byte ports and the nibble port
  logic [3:0][7:0] latch;
  logic [3:0] nib_latch;
  logic [3:0][7:0] sync1;
  logic [3:0][7:0] sync2;
  logic [3:0] nsync1;
  logic [3:0] nsync2;
  pio_pkg::pio_phase_t phase;
  logic [7:0] addr_hi;
  logic [7:0] data_byte;
  logic data_drive;
  logic [7:0] next_drv [4];
  logic [3:0][7:0] strong_act;
  logic [3:0] nib_strong;
  logic [7:0] tx_mux;

  // Latch writes from the core side
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      latch <= {4{pio_pkg::LATCH_RST}}; // see RULE_13
      nib_latch <= pio_pkg::NIB_RST; // see RULE_13
    end else begin
      for (int p = 0; p < 4; p++) begin
        if (wr_en[p]) begin
          latch[p] <= wr_data;
        end
      end
      if (wr_nib_en) begin
        nib_latch <= wr_data[3:0];
      end
    end
  end

  // Per-bit strong-high timers; one generate loop over all bits
  genvar g;
  generate
    for (g = 0; g < 36; g++) begin : g_strong
      logic [1:0] cnt;
      logic trig;
      // Zero-to-one write seen at the write edge itself
      if (g < 32) begin : g_byte
        assign trig = wr_en[g/8] & wr_data[g%8] & ~latch[g/8][g%8];
        assign strong_act[g/8][g%8] = (cnt != 2'h0);
      end else begin : g_nib
        assign trig = wr_nib_en & wr_data[g-32] & ~nib_latch[g-32];
        assign nib_strong[g-32] = (cnt != 2'h0);
      end
      // Loaded with the latch so strong drive starts with the new high
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          cnt <= 2'h0;
        end else if (trig) begin
          cnt <= pio_pkg::STRONG_CYC; // see RULE_04
        end else if (cnt != 2'h0) begin
          cnt <= cnt - 2'h1;
        end
      end
    end
  endgenerate

  // Two-flop pin synchronisers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= '1;
      sync2 <= '1;
      nsync1 <= '1;
      nsync2 <= '1;
    end else begin
      sync1 <= {fourth_in, high_in, second_in, low_in};
      sync2 <= sync1; // see RULE_14
      nsync1 <= nib_in;
      nsync2 <= nsync1;
    end
  end

  // External access sequencer: address phase then data phase
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= pio_pkg::PIO_IDLE;
      addr_hi <= 8'h00;
      data_byte <= 8'h00;
      data_drive <= 1'b0;
    end else begin
      unique case (phase)
        pio_pkg::PIO_IDLE: begin
          if (ext_start) begin
            phase <= pio_pkg::PIO_ADDR;
            addr_hi <= ext_addr[15:8];
            data_byte <= ext_wdata;
            data_drive <= ext_write;
          end
        end
        pio_pkg::PIO_ADDR: phase <= pio_pkg::PIO_DATA;
        pio_pkg::PIO_DATA: phase <= pio_pkg::PIO_IDLE;
        default: phase <= pio_pkg::PIO_IDLE;
      endcase
    end
  end

  // Fourth port bit 1 carries serial transmit
  always_comb begin
    tx_mux = latch[3];
    tx_mux[1] = latch[3][1] & serial_tx; // see RULE_10
  end

  // Registered pin drivers; quasi pins drive low or strong high
  always_comb begin
    next_drv[1] = latch[1];
    if (timer_c_clk_out_en) begin
      next_drv[1][0] = timer_c_clk_out; // see RULE_05
    end
    next_drv[3] = tx_mux;
    next_drv[2] = latch[2];
    next_drv[0] = latch[0];
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_out <= 8'h00;
      low_oe <= 8'h00;
      high_out <= 8'hFF;
      high_oe <= 8'h00;
      second_out <= 8'hFF;
      second_oe <= 8'h00;
      fourth_out <= 8'hFF;
      fourth_oe <= 8'h00;
      nib_out <= 4'hF;
      nib_oe <= 4'h0;
      addr_latch <= 1'b0;
    end else begin
      addr_latch <= ext_start && (phase == pio_pkg::PIO_IDLE); // see RULE_09
      if (phase == pio_pkg::PIO_IDLE && !ext_start) begin
        low_out <= 8'h00;
        low_oe <= ~latch[0]; // see RULE_02
        high_out <= latch[2]; // see RULE_07
        high_oe <= ~latch[2] | strong_act[2];
      end else if (phase == pio_pkg::PIO_IDLE) begin
        low_out <= ext_addr[7:0]; // see RULE_03
        low_oe <= 8'hFF;
        high_out <= ext_addr[15:8]; // see RULE_08
        high_oe <= 8'hFF;
      end else begin
        low_out <= data_byte;
        low_oe <= {8{data_drive}}; // see RULE_03
        high_out <= addr_hi; // see RULE_08
        high_oe <= 8'hFF;
      end
      // Weak pull-up is outside; module drives low or pulsed high, except second port bit 0, driven both ways while clock out is enabled
      second_out <= next_drv[1]; // see RULE_01
      second_oe <= ~next_drv[1] | strong_act[1] |
                   {7'h00, timer_c_clk_out_en};
      fourth_out <= next_drv[3];
      fourth_oe <= ~next_drv[3] | strong_act[3];
      nib_out <= nib_latch;
      nib_oe <= ~nib_latch | nib_strong;
    end
  end

  // Read-back and alternate inputs from synchronized pins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_low <= 8'hFF;
      rd_second <= 8'hFF;
      rd_high <= 8'hFF;
      rd_fourth <= 8'hFF;
      rd_nib <= 4'hF;
      timer_c_event_or_clock_out <= 1'b1;
      timer_c_capture_control_in <= 1'b1;
      serial_rx <= 1'b1;
      external_irq_a <= 1'b1;
      external_irq_b <= 1'b1;
      timer_a_event_in <= 1'b1;
      timer_b_event_in <= 1'b1;
    end else begin
      rd_low <= sync2[0]; // see RULE_14
      rd_second <= sync2[1];
      rd_high <= sync2[2];
      rd_fourth <= sync2[3];
      rd_nib <= nsync2;
      timer_c_event_or_clock_out <= sync2[1][0]; // see RULE_05
      timer_c_capture_control_in <= sync2[1][1]; // see RULE_06
      serial_rx <= sync2[3][0]; // see RULE_10
      external_irq_a <= sync2[3][2]; // see RULE_11
      external_irq_b <= sync2[3][3]; // see RULE_11
      timer_a_event_in <= sync2[3][4]; // see RULE_12
      timer_b_event_in <= sync2[3][5]; // see RULE_12
    end
  end
endmodule

// File: testbench/pio_far.sv
`timescale 1ns/1ps
// Pins seen from outside: weak pull-ups, outside logic on low port
module pio_far (
  input wire logic [7:0] low_ext,
  input wire logic [7:0] low_out,
  input wire logic [7:0] low_oe,
  input wire logic [7:0] second_out,
  input wire logic [7:0] second_oe,
  input wire logic [7:0] high_out,
  input wire logic [7:0] high_oe,
  input wire logic [7:0] fourth_out,
  input wire logic [7:0] fourth_oe,
  input wire logic [3:0] nib_out,
  input wire logic [3:0] nib_oe,
  output logic [7:0] low_in,
  output logic [7:0] second_in,
  output logic [7:0] high_in,
  output logic [7:0] fourth_in,
  output logic [3:0] nib_in
);
  // Released bits show the outside level, never a stale one
  assign low_in = (low_oe & low_out) | (~low_oe & low_ext);
  // Undriven quasi bits float up
  assign second_in = second_out | ~second_oe;
  assign high_in = high_out | ~high_oe;
  assign fourth_in = fourth_out | ~fourth_oe;
  assign nib_in = nib_out | ~nib_oe;
endmodule

// File: testbench/pio_ports_checker.sv
`timescale 1ns/1ps
module pio_ports_checker (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ext_start,
  input wire logic [15:0] ext_addr,
  input wire logic addr_latch,
  input wire logic [7:0] low_out,
  input wire logic [7:0] low_oe,
  input wire logic [7:0] high_out,
  input wire logic [7:0] high_oe,
  input wire logic [7:0] second_out,
  input wire logic [7:0] second_oe,
  input wire logic [7:0] second_in,
  input wire logic [7:0] rd_second
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // Strobe and strong-pull phases
  sequence one_pulse;
    addr_latch ##1 !addr_latch;
  endsequence
  sequence strong_two;
    (second_oe[2] && second_out[2]) [*2] ##1 !second_oe[2];
  endsequence
  // Drive and strobe against their causes
  reset_state_a: assert property (
    $rose(rst_n) |-> low_oe == 8'h00 && second_oe == 8'h00 && !addr_latch)
    else $error("drive after reset");
  latch_cause_a: assert property (
    addr_latch |-> $past(ext_start)) else $error("stray strobe");
  latch_pulse_a: assert property (
    $rose(addr_latch) |-> one_pulse) else $error("strobe length");
  low_addr_a: assert property (
    addr_latch |-> low_oe == 8'hFF && low_out == $past(ext_addr[7:0]))
    else $error("low address");
  high_addr_a: assert property (
    addr_latch |-> high_oe == 8'hFF && high_out == $past(ext_addr[15:8]))
    else $error("high address");
  open_drain_a: assert property (
    (low_oe & low_out) != 8'h00 |-> addr_latch || $past(addr_latch) ||
    $past(addr_latch, 2)) else $error("low port drove high");
  strong_high_a: assert property (
    $rose(second_oe[2] && second_out[2]) |-> strong_two)
    else $error("strong drive length");
  // History taken before a reset would not match the flushed stages
  pin_sync_a: assert property (
    $past(rst_n) && $past(rst_n, 2) && $past(rst_n, 3) |->
    rd_second == $past(second_in, 3)) else $error("pin read latency");
endmodule
bind pio_ports pio_ports_checker u_chk (.*);

// File: testbench/test_parallel_io_ports.sv
`timescale 1ns/1ps
module test_parallel_io_ports;
  typedef struct {int p; logic [7:0] d; logic [7:0] e;} pio_row_t;
  logic ref_clk = 1'h0, rst_n = 1'h0, wr_nib_en = 1'h0, ext_start = 1'h0;
  logic ext_write = 1'h1, timer_c_clk_out_en = 1'h0, timer_c_clk_out = 1'h0;
  logic serial_tx = 1'h1, addr_latch, serial_rx, external_irq_a;
  logic external_irq_b, timer_a_event_in, timer_b_event_in;
  logic timer_c_event_or_clock_out, timer_c_capture_control_in;
  logic [3:0] wr_en = 4'h0, rd_nib, nib_in, nib_out, nib_oe;
  logic [7:0] wr_data = 8'h00, ext_wdata = 8'h3C, low_ext = 8'hFF;
  logic [15:0] ext_addr = 16'hA55A;
  logic [7:0] rd_low, rd_second, rd_high, rd_fourth, low_in, low_out, low_oe;
  logic [7:0] second_in, second_out, second_oe, high_in, high_out, high_oe;
  logic [7:0] fourth_in, fourth_out, fourth_oe, rd_v [5], alt;
  int err_total = 0, compares = 0;
  // Write value beside expected pin read, per port
  pio_row_t rows [8] = '{'{0, 8'h00, 8'h00}, '{0, 8'hFF, 8'hFF},
    '{1, 8'h00, 8'h00}, '{1, 8'hFF, 8'hFF}, '{2, 8'h3C, 8'h3C},
    '{2, 8'hFF, 8'hFF}, '{3, 8'h5A, 8'h5A}, '{4, 8'hF6, 8'h06}};
  pio_ports uut (.*);
  pio_far far (.*);
  // Read views gathered for table-driven compares
  assign rd_v = '{rd_low, rd_second, rd_high, rd_fourth, {4'h0, rd_nib}};
  assign alt = {1'h0, timer_c_event_or_clock_out, timer_c_capture_control_in,
    serial_rx, external_irq_a, external_irq_b, timer_a_event_in,
    timer_b_event_in};
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Ends at a falling edge so reads never race the design
  task automatic wr(input int p, input logic [7:0] d);
    @(posedge ref_clk);
    wr_en <= 4'(1 << p);
    wr_nib_en <= p == 4;
    wr_data <= d;
    @(posedge ref_clk);
    wr_en <= 4'h0;
    wr_nib_en <= 1'h0;
    repeat (6) @(negedge ref_clk);
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial forever #25 ref_clk = ~ref_clk;
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'h1;
    @(negedge ref_clk);
    foreach (rd_v[i]) chk(rd_v[i], i == 4 ? 8'h0F : 8'hFF);
    $display("reset test done");
    foreach (rows[i]) begin
      wr(rows[i].p, rows[i].d);
      chk(rd_v[rows[i].p], rows[i].e);
    end
    $display("row test done");
    wr(3, 8'hCB);
    chk(alt, 8'h74);
    wr(1, 8'hFD);
    chk(alt, 8'h54);
    @(posedge ref_clk);
    timer_c_clk_out_en <= 1'h1;
    serial_tx <= 1'h0;
    repeat (6) @(negedge ref_clk);
    chk(alt, 8'h14);
    chk(rd_fourth, 8'hC9);
    $display("alternate test done");
    // Strong high for two periods right after a zero-to-one write
    wr(2, 8'h00);
    @(posedge ref_clk);
    wr_en <= 4'h4;
    wr_data <= 8'hFF;
    @(posedge ref_clk);
    wr_en <= 4'h0;
    @(negedge ref_clk);
    chk(high_oe, 8'hFF);
    repeat (2) begin
      @(negedge ref_clk);
      chk(high_out & high_oe, 8'hFF);
    end
    @(negedge ref_clk);
    chk(high_oe, 8'h00);
    $display("strong drive test done");
    @(posedge ref_clk);
    ext_start <= 1'h1;
    @(posedge ref_clk);
    ext_start <= 1'h0;
    @(negedge ref_clk);
    repeat (4) if (addr_latch !== 1'h1) @(negedge ref_clk);
    if (addr_latch !== 1'h1) begin
      err_total++;
      $display("CHECK FAILED %0t no address strobe", $time);
      report_and_stop;
    end
    chk(low_in, 8'h5A);
    chk(high_in, 8'hA5);
    @(negedge ref_clk);
    chk(low_in, 8'h3C);
    chk(high_in, 8'hA5);
    @(posedge ref_clk);
    low_ext <= 8'h96;
    repeat (6) @(negedge ref_clk);
    chk(rd_low, 8'h96);
    // Read access: low port released in the data phase
    @(posedge ref_clk);
    ext_write <= 1'h0;
    ext_addr <= 16'h5AA5;
    ext_start <= 1'h1;
    @(posedge ref_clk);
    ext_start <= 1'h0;
    @(negedge ref_clk);
    chk(low_in, 8'hA5);
    @(negedge ref_clk);
    chk(low_in, 8'h96);
    chk(high_in, 8'h5A);
    $display("access test done");
    // Second reset in mid-run: drivers off, latches back to ones
    @(posedge ref_clk);
    rst_n <= 1'h0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'h1;
    @(negedge ref_clk);
    chk(low_oe | second_oe | fourth_oe, 8'h00);
    repeat (6) @(negedge ref_clk);
    chk(rd_fourth, 8'hFD);
    $display("reset again test done");
    report_and_stop;
  end
endmodule
